//--- src/frc_station.sv
// Remote-station command interpreter of a fieldbus motor drive
// ==========================================================
// Overview of operation
// (R1) Code 0x87 with data stores acceleration time; reply code returned.
// (R2) Master sets extended setting nonzero before parameters numbered 100 up.
// (R3) Set-frequency data are in 0.01 Hz units; 5000 means 50.00 Hz.
// (R4) Frequency result goes to frequency reply word, not instruction reply.
// (R5) Master waits for done flag and zero reply before new frequency.
// (R6) EEPROM frequency write uses its own command and completion bits.
// (R7) Exactly one EEPROM write per rising edge of EEPROM command; none with link down, data over FREQ_MAX or a write in progress.
// (R8) Frequency data changes ignored while EEPROM command stays on.
// (R9) Code 0x74 returns fault history entries one and two plus reply.
// (R10) Fault-reset request acts only while a fault is present.
// (R11) Communication reset select 0 allows reset in any mode.
// (R12) Code 0xFD data 0x9696 resets only if startup nonzero or net mode.
// (R13) In network mode operation commands come only from the master.
// (R14) Stopped data exchange in network mode trips link-loss fault.
// (R15) Startup 0 starts external mode; nonzero starts network mode.
// (R16) Light profile links only at 100 Mbps, never at 10 Mbps.
// (R17) Light profile: 64 bits each way, 32 words each way.
// (R18) Light profile answers a master command within 15 ms.
// (R19) One master serves at most 64 stations, 4 groups of 16.
// (R20) Any function select 61450 enables light unless some holds 45238.
// (R21) Function select changes take effect only after reset.
// (R22) Code 0xFB changes operation mode; data 0x0000 selects network.
// (R23) Code 0x07 returns acceleration time in the read word.
// (R24) Reply code and read data are written before the completion bit; code writes them in the same cycle as it.
// (R25) Completion bits clear after the matching request is removed.
//
`timescale 1ns/1ps

module frc_station #(
  parameter int LOSS_CYCLES = frc_pkg::LOSS_CYCLES_DEF,
  parameter int EEPROM_CYCLES = frc_pkg::EEPROM_CYCLES_DEF
) (
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  input wire frc_pkg::frc_cmd_t CMD_IN,
  input wire logic [7:0] INSTR_CODE_IN,
  input wire logic [15:0] INSTR_DATA_IN,
  input wire logic [15:0] FREQ_DATA_IN,
  input wire logic FRAME_VALID_IN,
  input wire logic LINK_UP_IN,
  input wire logic LINK_100M_IN,
  input wire logic [1:0] EXT_OPCMD_IN,
  input wire logic [1:0] NET_OPCMD_IN,
  input wire logic [63:0] ETH_FUNC_IN,
  input wire logic [7:0] STARTUP_MODE_IN,
  input wire logic COMM_RESET_SEL_IN,
  input wire logic FAULT_IN,
  input wire logic [7:0] FAULT_CODE_IN,
  input wire logic EEPROM_READY_IN,
  output frc_pkg::frc_stat_t STAT_OUT,
  output logic [15:0] INSTR_REPLY_OUT,
  output logic [15:0] FREQ_REPLY_OUT,
  output logic [15:0] READ_WORD_OUT,
  output logic [15:0] FREQ_SET_OUT,
  output logic [15:0] ACCEL_TIME_OUT,
  output logic EEPROM_WRITE_OUT,
  output logic [15:0] EEPROM_DATA_OUT,
  output logic [1:0] OPCMD_OUT,
  output logic LINK_LOSS_FAULT_OUT,
  output logic LIGHT_ENABLE_OUT,
  output logic LINK_ACTIVE_OUT,
  output logic DRIVE_RESET_OUT
);

  if (LOSS_CYCLES < 1 || EEPROM_CYCLES < 1)
  begin : g_bad_counts
    $error("Cycle counts must be at least one");
  end

  // ==========================================================
  // Station image: command bits and the six words in use must
  // fit one station's share of the light profile
  localparam int BITS_USED = $bits(frc_pkg::frc_cmd_t);
  localparam int WORDS_USED = 6;
  if (BITS_USED > frc_pkg::RBIT_COUNT || WORDS_USED > frc_pkg::RWORD_COUNT) // R17
  begin : g_bad_image
    $error("Station image exceeds the light profile share");
  end

  // Answers land one cycle after the take; a budget under two cycles is unusable
  if (frc_pkg::RESP_CYCLES < 2) // R18
  begin : g_bad_resp
    $error("Response budget shorter than the answer latency");
  end

  typedef enum logic [2:0] {
    FRC_E_IDLE = 3'b001,
    FRC_E_WRITE = 3'b010,
    FRC_E_DONE = 3'b100
  } frc_ee_t;

  function automatic logic func_has(input logic [63:0] f, input logic [15:0] v);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < frc_pkg::ETH_FUNC_COUNT; i++)
      if (f[16*i +: 16] == v)
        hit = 1'b1;
    return hit;
  endfunction

  // ==========================================================
  // State
  logic boot_q;
  logic light_q;
  logic net_q;
  logic exec_done_q;
  logic ram_done_q;
  logic ee_cmd_q;
  logic [15:0] instr_reply_q;
  logic [15:0] freq_reply_q;
  logic [15:0] read_word_q;
  logic [15:0] freq_q;
  logic [15:0] accel_q;
  logic [15:0] ee_data_q;
  logic [7:0] fault1_q;
  logic [7:0] fault2_q;
  logic prev_fault_q;
  logic loss_q;
  logic reset_q;
  logic [31:0] loss_cnt_q;
  logic [31:0] ee_cnt_q;
  frc_ee_t ee_q;

  // ==========================================================
  // Decode
  wire light_sel = func_has(ETH_FUNC_IN, frc_pkg::FUNC_LIGHT)
    && !func_has(ETH_FUNC_IN, frc_pkg::FUNC_TSN); // R20
  wire link_ok = light_q && LINK_UP_IN && LINK_100M_IN; // R16
  wire exec_start = CMD_IN.exec_req && !exec_done_q;
  wire is_wr_accel = INSTR_CODE_IN == frc_pkg::CODE_ACCEL_WRITE;
  wire is_rd_accel = INSTR_CODE_IN == frc_pkg::CODE_ACCEL_READ;
  wire is_fault_rd = INSTR_CODE_IN == frc_pkg::CODE_FAULT_READ;
  wire is_mode = INSTR_CODE_IN == frc_pkg::CODE_MODE_WRITE;
  wire is_reset = INSTR_CODE_IN == frc_pkg::CODE_RESET;
  wire reset_allowed = (STARTUP_MODE_IN != 8'h00) || net_q; // R12
  wire reset_key_ok = INSTR_DATA_IN == frc_pkg::DATA_RESET_KEY;
  wire mode_ok = INSTR_DATA_IN == frc_pkg::DATA_MODE_NET
    || INSTR_DATA_IN == frc_pkg::DATA_MODE_EXT;
  wire freq_ok = FREQ_DATA_IN <= frc_pkg::FREQ_MAX;
  wire ee_rise = CMD_IN.freq_cmd_eeprom && !ee_cmd_q;
  wire fault_reset = CMD_IN.fault_reset_req && FAULT_IN
    && (COMM_RESET_SEL_IN == 1'b0 || net_q); // R10 R11
  // Refused with no answer while the link is down, like any other instruction
  wire cmd_reset = exec_start && link_ok && is_reset && reset_key_ok && reset_allowed; // R12
  // Storage completion also reports in the frequency reply word
  wire ee_write = ee_q == FRC_E_WRITE && ee_cnt_q == 32'd0 && EEPROM_READY_IN; // R7

  logic [15:0] reply_d;
  logic [15:0] read_d;
  always_comb
  begin
    reply_d = frc_pkg::REPLY_OK;
    read_d = read_word_q;
    if (is_wr_accel)
      reply_d = frc_pkg::REPLY_OK; // R1
    else if (is_rd_accel)
      read_d = accel_q; // R23
    else if (is_fault_rd)
      read_d = {fault2_q, fault1_q}; // R9
    else if (is_mode)
      reply_d = mode_ok ? frc_pkg::REPLY_OK : frc_pkg::REPLY_BAD_DATA; // R22
    else if (is_reset)
      reply_d = (reset_key_ok && reset_allowed) ? frc_pkg::REPLY_OK
        : frc_pkg::REPLY_BAD_DATA;
    else
      reply_d = frc_pkg::REPLY_BAD_CODE;
  end

  // ==========================================================
  // Boot: function select and startup mode sampled only once after reset; reset_allowed also reads startup mode every cycle
  always_ff @(posedge CLK_IN)
  begin
    if (!RST_B_IN)
    begin
      boot_q <= 1'b1;
      light_q <= 1'b0;
    end
    else if (boot_q)
    begin
      boot_q <= 1'b0;
      light_q <= light_sel; // R21
    end
  end

  // ==========================================================
  // Instruction handshake
  always_ff @(posedge CLK_IN)
  begin
    if (!RST_B_IN)
    begin
      exec_done_q <= 1'b0;
      instr_reply_q <= 16'h0000;
      read_word_q <= 16'h0000;
      accel_q <= frc_pkg::ACCEL_RESET;
      net_q <= 1'b0;
      reset_q <= 1'b0;
    end
    else
    begin
      reset_q <= cmd_reset || fault_reset;
      if (boot_q)
        net_q <= STARTUP_MODE_IN != 8'h00; // R15
      else if (loss_q)
        net_q <= 1'b0;
      if (!CMD_IN.exec_req)
        exec_done_q <= 1'b0; // R25
      else if (exec_start && link_ok)
      begin
        instr_reply_q <= reply_d; // R24
        read_word_q <= read_d;
        exec_done_q <= 1'b1; // R24 R18
        if (is_wr_accel)
          accel_q <= INSTR_DATA_IN; // R1
        if (is_mode && mode_ok)
          net_q <= INSTR_DATA_IN == frc_pkg::DATA_MODE_NET; // R22
      end
    end
  end

  // ==========================================================
  // Fault history: newest entry first
  always_ff @(posedge CLK_IN)
  begin
    if (!RST_B_IN)
    begin
      prev_fault_q <= 1'b0;
      fault1_q <= 8'h00;
      fault2_q <= 8'h00;
    end
    else
    begin
      prev_fault_q <= FAULT_IN || loss_q;
      if ((FAULT_IN || loss_q) && !prev_fault_q)
      begin
        fault2_q <= fault1_q;
        fault1_q <= loss_q ? 8'hFF : FAULT_CODE_IN;
      end
    end
  end

  // ==========================================================
  // Frequency RAM path; data held in 0.01 Hz units
  always_ff @(posedge CLK_IN)
  begin
    if (!RST_B_IN)
    begin
      ram_done_q <= 1'b0;
      freq_q <= 16'h0000;
      freq_reply_q <= 16'h0000;
    end
    else
    begin
      if (!CMD_IN.freq_cmd_ram)
        ram_done_q <= 1'b0; // R25
      else if (!ram_done_q && link_ok)
      begin
        if (freq_ok)
          freq_q <= FREQ_DATA_IN; // R3
        freq_reply_q <= freq_ok ? frc_pkg::REPLY_OK : frc_pkg::REPLY_BAD_DATA; // R4
        ram_done_q <= 1'b1;
      end
      // Storage result must land even while the RAM command is down
      if (ee_write)
        freq_reply_q <= frc_pkg::REPLY_OK; // R4
    end
  end

  // ==========================================================
  // Frequency EEPROM path: at most one write per command edge, data latched
  always_ff @(posedge CLK_IN)
  begin
    if (!RST_B_IN)
    begin
      ee_q <= FRC_E_IDLE;
      ee_cmd_q <= 1'b0;
      ee_data_q <= 16'h0000;
      ee_cnt_q <= 32'd0;
    end
    else
    begin
      ee_cmd_q <= CMD_IN.freq_cmd_eeprom;
      case (ee_q)
        FRC_E_IDLE:
          if (ee_rise && link_ok && freq_ok) // R6 R7
          begin
            ee_data_q <= FREQ_DATA_IN; // R8
            ee_cnt_q <= 32'(EEPROM_CYCLES - 1);
            ee_q <= FRC_E_WRITE;
          end
        FRC_E_WRITE:
          if (ee_cnt_q != 32'd0)
            ee_cnt_q <= ee_cnt_q - 32'd1;
          else if (EEPROM_READY_IN)
            ee_q <= FRC_E_DONE;
        FRC_E_DONE:
          if (!CMD_IN.freq_cmd_eeprom)
            ee_q <= FRC_E_IDLE; // R25
        default:
          ee_q <= FRC_E_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Link loss watchdog while in network mode
  always_ff @(posedge CLK_IN)
  begin
    if (!RST_B_IN)
    begin
      loss_cnt_q <= 32'd0;
      loss_q <= 1'b0;
    end
    else if (!net_q || FRAME_VALID_IN)
      loss_cnt_q <= 32'd0;
    else if (loss_cnt_q == 32'(LOSS_CYCLES - 1))
      loss_q <= 1'b1; // R14
    else
      loss_cnt_q <= loss_cnt_q + 32'd1;
  end

  // ==========================================================
  // Outputs
  assign STAT_OUT.exec_done = exec_done_q;
  assign STAT_OUT.freq_done_ram = ram_done_q;
  assign STAT_OUT.freq_done_eeprom = ee_q == FRC_E_DONE; // R6
  assign STAT_OUT.net_mode = net_q;
  assign INSTR_REPLY_OUT = instr_reply_q;
  assign FREQ_REPLY_OUT = freq_reply_q;
  assign READ_WORD_OUT = read_word_q;
  assign FREQ_SET_OUT = freq_q;
  assign ACCEL_TIME_OUT = accel_q;
  assign EEPROM_WRITE_OUT = ee_write; // R7
  assign EEPROM_DATA_OUT = ee_data_q;
  assign OPCMD_OUT = net_q ? NET_OPCMD_IN : EXT_OPCMD_IN; // R13
  assign LINK_LOSS_FAULT_OUT = loss_q;
  assign LIGHT_ENABLE_OUT = light_q;
  assign LINK_ACTIVE_OUT = link_ok; // R16 R17
  assign DRIVE_RESET_OUT = reset_q;

endmodule

//--- src/frc_pkg.sv
// Package of constants and carriers for the remote-station command interpreter
package frc_pkg;

  // ==========================================================
  // Instruction codes and data
  localparam logic [7:0] CODE_ACCEL_WRITE = 8'h87;
  localparam logic [7:0] CODE_ACCEL_READ = 8'h07;
  localparam logic [7:0] CODE_FAULT_READ = 8'h74;
  localparam logic [7:0] CODE_MODE_WRITE = 8'hFB;
  localparam logic [7:0] CODE_RESET = 8'hFD;
  localparam logic [15:0] DATA_RESET_KEY = 16'h9696;
  localparam logic [15:0] DATA_MODE_NET = 16'h0000;
  localparam logic [15:0] DATA_MODE_EXT = 16'h0010;

  // ==========================================================
  // Reply codes
  localparam logic [15:0] REPLY_OK = 16'h0000;
  localparam logic [15:0] REPLY_BAD_CODE = 16'h0001;
  localparam logic [15:0] REPLY_BAD_DATA = 16'h0003;
  localparam logic [15:0] REPLY_NO_EXT = 16'h0002;

  // ==========================================================
  // Parameter limits, reset values and function select codes
  localparam logic [15:0] ACCEL_RESET = 16'h0032;
  localparam logic [15:0] FREQ_MAX = 16'h9C40;
  localparam logic [15:0] FUNC_LIGHT = 16'hF00A;
  localparam logic [15:0] FUNC_TSN = 16'hB0B6;
  localparam int ETH_FUNC_COUNT = 4;

  // ==========================================================
  // Link sizes
  localparam int RBIT_COUNT = 64;
  localparam int RWORD_COUNT = 32;

  // ==========================================================
  // Timing
  localparam int CLK_MHZ = 250;
  localparam int RESP_TIME_MS = 15;
  localparam int RESP_CYCLES = RESP_TIME_MS * CLK_MHZ * 1000;
  localparam int LOSS_CYCLES_DEF = 375000000;
  localparam int EEPROM_CYCLES_DEF = 5000;

  // ==========================================================
  // Carriers
  typedef struct packed {
    logic exec_req;
    logic fault_reset_req;
    logic freq_cmd_ram;
    logic freq_cmd_eeprom;
  } frc_cmd_t;

  typedef struct packed {
    logic exec_done;
    logic freq_done_ram;
    logic freq_done_eeprom;
    logic net_mode;
  } frc_stat_t;

endpackage

//--- dv/frc_station_props.sv
// Port assertions for the remote-station command interpreter
`timescale 1ns/1ps
module frc_station_props (
  input wire logic CLK_IN,
  input wire logic RST_B_IN,
  input wire frc_pkg::frc_cmd_t CMD_IN,
  input wire logic [7:0] INSTR_CODE_IN,
  input wire logic [15:0] INSTR_DATA_IN,
  input wire logic [15:0] FREQ_DATA_IN,
  input wire logic LINK_UP_IN,
  input wire logic LINK_100M_IN,
  input wire logic [1:0] EXT_OPCMD_IN,
  input wire logic [1:0] NET_OPCMD_IN,
  input wire frc_pkg::frc_stat_t STAT_OUT,
  input wire logic [15:0] ACCEL_TIME_OUT,
  input wire logic [15:0] FREQ_SET_OUT,
  input wire logic EEPROM_WRITE_OUT,
  input wire logic [15:0] EEPROM_DATA_OUT,
  input wire logic [1:0] OPCMD_OUT,
  input wire logic LIGHT_ENABLE_OUT,
  input wire logic LINK_ACTIVE_OUT,
  input wire logic DRIVE_RESET_OUT
);
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (!RST_B_IN);
  wire take;
  logic [1:0] wr_cnt_q;
  logic [15:0] ee_lat_q;
  assign take = CMD_IN.exec_req & ~STAT_OUT.exec_done & LINK_ACTIVE_OUT;
  // Saturating, so a runaway writer cannot wrap back to a legal count
  always_ff @(posedge CLK_IN)
  begin
    if (!CMD_IN.freq_cmd_eeprom)
      wr_cnt_q <= 2'h0;
    else if (EEPROM_WRITE_OUT && wr_cnt_q != 2'h3)
      wr_cnt_q <= wr_cnt_q + 2'h1;
  end
  always_ff @(posedge CLK_IN)
  begin
    if ($rose(CMD_IN.freq_cmd_eeprom))
      ee_lat_q <= FREQ_DATA_IN;
  end
  property p_link;
    LINK_ACTIVE_OUT == (LIGHT_ENABLE_OUT && LINK_UP_IN && LINK_100M_IN); endproperty
  a_link: assert property (p_link) else $error("link active wrong");
  property p_opcmd; OPCMD_OUT == (STAT_OUT.net_mode ? NET_OPCMD_IN : EXT_OPCMD_IN); endproperty
  a_opcmd: assert property (p_opcmd) else $error("command source wrong");
  property p_accel; take && INSTR_CODE_IN == frc_pkg::CODE_ACCEL_WRITE &&
    INSTR_DATA_IN == 16'h001E |=> STAT_OUT.exec_done && ACCEL_TIME_OUT == 16'h001E; endproperty
  a_accel: assert property (p_accel) else $error("accel write wrong");
  property p_done_clr; STAT_OUT.exec_done && !CMD_IN.exec_req |=> !STAT_OUT.exec_done; endproperty
  a_done_clr: assert property (p_done_clr) else $error("done not cleared");
  property p_freq; CMD_IN.freq_cmd_ram && !STAT_OUT.freq_done_ram && LINK_ACTIVE_OUT &&
    FREQ_DATA_IN <= frc_pkg::FREQ_MAX |=> STAT_OUT.freq_done_ram &&
    FREQ_SET_OUT == $past(FREQ_DATA_IN); endproperty
  a_freq: assert property (p_freq) else $error("freq set wrong");
  property p_ee_once; wr_cnt_q <= 2'h1; endproperty
  a_ee_once: assert property (p_ee_once) else $error("repeated storage write");
  property p_ee_data; EEPROM_WRITE_OUT |-> EEPROM_DATA_OUT == ee_lat_q ##1
    STAT_OUT.freq_done_eeprom; endproperty
  a_ee_data: assert property (p_ee_data) else $error("storage write wrong");
  property p_key; take && INSTR_CODE_IN == frc_pkg::CODE_RESET && STAT_OUT.net_mode &&
    INSTR_DATA_IN == frc_pkg::DATA_RESET_KEY |=> DRIVE_RESET_OUT; endproperty
  a_key: assert property (p_key) else $error("keyed reset missing");
  c_ee: cover property (EEPROM_WRITE_OUT);
  c_rst: cover property (DRIVE_RESET_OUT);
  c_freq: cover property (STAT_OUT.freq_done_ram);
endmodule
bind frc_station frc_station_props frc_station_props_i (.*);

//--- dv/frc_master.sv
// Master station model: instruction handshake and frame pulses
`timescale 1ns/1ps
module frc_master (
  input wire logic clk_in,
  input wire logic done_in,
  input wire logic [15:0] reply_in,
  input wire logic [15:0] rd_in,
  input wire logic frames_in,
  output logic req_out,
  output logic [7:0] code_out,
  output logic [15:0] data_out,
  output logic frame_out = 1'b0
);
  initial
  begin
    req_out = 1'b0;
    code_out = 8'h00;
    data_out = 16'h0000;
  end
  // Serves this one station only
  always @(posedge clk_in) frame_out <= frames_in & ~frame_out;
  // Only low-numbered parameters are touched, so no extended setting is needed
  task automatic instr(input logic [7:0] c, input logic [15:0] d, output logic [15:0] rep,
    output logic [15:0] rd, output logic ok);
    int n;
    n = 0;
    code_out <= c;
    data_out <= d;
    req_out <= 1'b1;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (done_in !== 1'b1 && n < 20);
    ok = (n < 20);
    rep = reply_in;
    rd = rd_in;
    req_out <= 1'b0;
    n = 0;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (done_in !== 1'b0 && n < 20);
    ok = ok && (n < 20);
  endtask
endmodule

//--- dv/tb_top.sv
// Self-checking bench for the remote-station command interpreter
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic frr = 1'b0, fr = 1'b0, fe = 1'b0, frames = 1'b1, l100 = 1'b1, flt = 1'b0, lup = 1'b1;
  logic [15:0] fdat = 16'h0000;
  logic [7:0] fcode = 8'h00;
  logic [1:0] ext = 2'h1, net = 2'h2;
  logic req, frame, ok;
  logic [7:0] code;
  logic [15:0] data, rep, rd;
  frc_pkg::frc_stat_t st;
  wire [15:0] irep, frep, rword, fset, accel, edat;
  wire ewr, lloss, light, act, drst;
  wire [1:0] opc;
  int fail_count = 0, comparisons = 0, rcnt = 0, r0, n;
  always #2 clk = ~clk;
  always @(posedge clk) rcnt <= rcnt + int'(drst === 1'b1);
  frc_station #(.LOSS_CYCLES(50), .EEPROM_CYCLES(4)) frc_station_i (.CLK_IN(clk),
    .RST_B_IN(rst_b), .CMD_IN({req, frr, fr, fe}), .INSTR_CODE_IN(code), .INSTR_DATA_IN(data),
    .FREQ_DATA_IN(fdat), .FRAME_VALID_IN(frame), .LINK_UP_IN(lup), .LINK_100M_IN(l100),
    .EXT_OPCMD_IN(ext), .NET_OPCMD_IN(net), .ETH_FUNC_IN({32'h0, frc_pkg::FUNC_LIGHT, 16'h0}),
    .STARTUP_MODE_IN(8'h00), .COMM_RESET_SEL_IN(1'b0), .FAULT_IN(flt), .FAULT_CODE_IN(fcode),
    .EEPROM_READY_IN(1'b1), .STAT_OUT(st), .INSTR_REPLY_OUT(irep), .FREQ_REPLY_OUT(frep),
    .READ_WORD_OUT(rword), .FREQ_SET_OUT(fset), .ACCEL_TIME_OUT(accel), .EEPROM_WRITE_OUT(ewr),
    .EEPROM_DATA_OUT(edat), .OPCMD_OUT(opc), .LINK_LOSS_FAULT_OUT(lloss),
    .LIGHT_ENABLE_OUT(light), .LINK_ACTIVE_OUT(act), .DRIVE_RESET_OUT(drst));
  frc_master frc_master_i (.clk_in(clk), .done_in(st.exec_done), .reply_in(irep),
    .rd_in(rword), .frames_in(frames), .req_out(req), .code_out(code), .data_out(data),
    .frame_out(frame));
  task chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    comparisons++;
    if (s !== e)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask
  task give_verdict;
    if (fail_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task ins(input logic [7:0] c, input logic [15:0] d, input logic [15:0] erep);
    frc_master_i.instr(c, d, rep, rd, ok);
    chk("handshake", 16'h0001, ok);
    if (!ok)
      give_verdict;
    chk("reply", erep, rep);
  endtask
  task t_freq(input logic [15:0] d, input logic [15:0] erep, input logic [15:0] eset);
    n = 0;
    fdat <= d;
    fr <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (st.freq_done_ram !== 1'b1 && n < 20);
    chk("freq done", 16'h0001, st.freq_done_ram);
    if (n == 20)
      give_verdict;
    chk("freq reply", erep, frep);
    chk("freq set", eset, fset);
    fr <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task t_ee;
    r0 = 0;
    fdat <= 16'h1388;
    fe <= 1'b1;
    @(posedge clk);
    fdat <= 16'h0FA0;
    repeat (20)
    begin
      @(posedge clk);
      if (ewr === 1'b1)
      begin
        r0++;
        chk("storage data", 16'h1388, edat);
      end
    end
    chk("storage writes", 16'h0001, r0[15:0]);
    chk("storage done", 16'h0001, st.freq_done_eeprom);
    chk("ram done", 16'h0000, st.freq_done_ram);
    chk("storage reply", frc_pkg::REPLY_OK, frep);
    fe <= 1'b0;
    @(posedge clk);
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge clk);
    chk("accel reset", frc_pkg::ACCEL_RESET, accel);
    chk("net mode", 16'h0000, st.net_mode);
    chk("light", 16'h0001, light);
    chk("opcmd", 16'h0001, opc);
    l100 <= 1'b0;
    @(posedge clk);
    chk("slow link", 16'h0000, act);
    l100 <= 1'b1;
    lup <= 1'b0;
    @(posedge clk);
    chk("link down", 16'h0000, act);
    lup <= 1'b1;
    ins(frc_pkg::CODE_MODE_WRITE, frc_pkg::DATA_MODE_NET, frc_pkg::REPLY_OK);
    chk("net mode", 16'h0001, st.net_mode);
    chk("opcmd", 16'h0002, opc);
    ins(frc_pkg::CODE_ACCEL_WRITE, 16'd30, frc_pkg::REPLY_OK);
    chk("accel", 16'd30, accel);
    ins(frc_pkg::CODE_ACCEL_READ, 16'h0000, frc_pkg::REPLY_OK);
    chk("accel read", 16'd30, rd);
    t_freq(16'd5000, frc_pkg::REPLY_OK, 16'd5000);
    t_freq(16'h9C41, frc_pkg::REPLY_BAD_DATA, 16'd5000);
    t_ee;
    frr <= 1'b1;
    repeat (3) @(posedge clk);
    chk("reset no fault", 16'h0000, rcnt[15:0]);
    frr <= 1'b0;
    flt <= 1'b1;
    fcode <= 8'h21;
    @(posedge clk);
    ins(frc_pkg::CODE_FAULT_READ, 16'h0000, frc_pkg::REPLY_OK);
    chk("history", 16'h0021, rd);
    frr <= 1'b1;
    repeat (3) @(posedge clk);
    chk("fault reset", 16'h0001, 16'(rcnt != 0));
    frr <= 1'b0;
    flt <= 1'b0;
    // Let the held fault-reset pulses drain before taking the snapshot
    repeat (2) @(posedge clk);
    r0 = rcnt;
    ins(frc_pkg::CODE_RESET, frc_pkg::DATA_RESET_KEY, frc_pkg::REPLY_OK);
    chk("keyed reset", 16'h0001, 16'(rcnt != r0));
    frames <= 1'b0;
    n = 0;
    while (lloss !== 1'b1 && n < 80)
    begin
      @(posedge clk);
      n++;
    end
    chk("link loss", 16'h0001, lloss);
    @(posedge clk);
    chk("loss mode", 16'h0000, st.net_mode);
    r0 = rcnt;
    ins(frc_pkg::CODE_RESET, frc_pkg::DATA_RESET_KEY, frc_pkg::REPLY_BAD_DATA);
    chk("keyed reset refused", 16'h0000, 16'(rcnt != r0));
    ins(frc_pkg::CODE_FAULT_READ, 16'h0000, frc_pkg::REPLY_OK);
    chk("loss history", 16'h21FF, rd);
    give_verdict;
  end
endmodule
